// file: rtl/rpms_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module rpms_sequencer
  import rpms_pkg::*;
#(
  parameter int unsigned POR_CYCLES = 1 << rpms_pkg::POR_EXT_LOG2
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_por,
  input  wire logic             i_ext_rst,
  input  wire logic             i_sw_rst,
  input  wire logic             i_wdog_rst,
  input  wire logic             i_stop_insn,
  input  wire logic             i_wait_insn,
  input  wire logic             i_dis_temp,
  input  wire logic             i_dis_perm,
  input  wire logic             i_dis_wr,
  input  wire logic             i_periph_irq,
  input  wire logic             i_unclk_irq,
  input  wire logic             i_can_act,
  input  wire logic [15:0]      i_sec_bytes,
  output rpms_pkg::rpms_clk_s   o_clk_en,
  output rpms_pkg::rpms_rst_s   o_rst_n,
  output rpms_pkg::rpms_pwr_e   o_pwr_mode,
  output logic                  o_secure,
  output logic                  o_dbg_rd_dis,
  output logic                  o_dbg_port_en,
  output logic                  o_tap_en,
  output logic                  o_stopwait_dis
);
  import rpms_pkg::*;

  localparam logic [CNT_W-1:0] POR_CNT = CNT_W'(POR_CYCLES - 1);
  localparam logic [CNT_W-1:0] WIN_CNT = CNT_W'(WINDOW_CYCLES - 1);
  localparam logic [CNT_W-1:0] WIN_LEN = CNT_W'(WINDOW_CYCLES);

  logic             half_en;
  logic             any_rst;
  logic             por_seen_q;
  logic [CNT_W-1:0] cnt_q;
  rpms_rst_e        rst_st_q;
  rpms_pwr_e        pwr_q;
  logic             dis_temp_q;
  logic             dis_perm_q;
  logic             secure_q;
  rpms_clk_s        clk_en_q;
  rpms_rst_s        rst_n_q;
  logic             dbg_rd_dis_q;
  logic             dbg_port_en_q;
  logic             tap_en_q;
  logic             stopwait_dis_q;
  rpms_rst_e        win_st_q;
  logic [CNT_W-1:0] win_len_q;

  rpms_clkdiv u_div (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .o_half_en (half_en)
  );

  // All four sources funnel into one sequence so release order never depends on cause.
  assign any_rst = i_por | i_ext_rst | i_sw_rst | i_wdog_rst; // R09 R16

  // The synchronous bench reset stands in for power-on; the POR input extends it too.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      por_seen_q <= 1'b1;
    end else if (i_por) begin
      por_seen_q <= 1'b1;
    end else if (rst_st_q == RPMS_RST_CLK) begin
      por_seen_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rst_st_q <= RPMS_RST_HOLD;
      cnt_q    <= '0;
    end else if (any_rst) begin
      rst_st_q <= RPMS_RST_HOLD;
      cnt_q    <= '0;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
      unique case (rst_st_q)
        RPMS_RST_HOLD: begin
          // Only a power-on needs the long stabilisation extension.
          if (!por_seen_q || cnt_q == POR_CNT) begin // R10
            rst_st_q <= RPMS_RST_CLK;
            cnt_q    <= '0;
          end
        end
        RPMS_RST_CLK: begin
          if (cnt_q == WIN_CNT) begin // R10
            rst_st_q <= RPMS_RST_PERI;
            cnt_q    <= '0;
          end
        end
        RPMS_RST_PERI: begin
          if (cnt_q == WIN_CNT) begin // R10
            rst_st_q <= RPMS_RST_CORE;
            cnt_q    <= '0;
          end
        end
        RPMS_RST_CORE: begin
          if (cnt_q == WIN_CNT) begin // R10
            rst_st_q <= RPMS_RST_DONE;
            cnt_q    <= '0;
          end
        end
        RPMS_RST_DONE: begin
          cnt_q <= '0;
        end
      endcase
    end
  end

  // Releases are registered, so they always fall on a rising clock edge.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || any_rst) begin
      rst_n_q <= '0;
    end else begin
      rst_n_q.sim_rst_n  <= (rst_st_q != RPMS_RST_HOLD); // R11 R16
      rst_n_q.peri_rst_n <= (rst_st_q == RPMS_RST_CORE) || (rst_st_q == RPMS_RST_DONE); // R16
      rst_n_q.core_rst_n <= (rst_st_q == RPMS_RST_DONE); // R16
    end
  end

  // Check-only timer: it measures how long the previous reset state lasted, so a miscounted
  // window is caught without unrolling a long repetition.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || any_rst) begin
      win_st_q  <= RPMS_RST_HOLD;
      win_len_q <= '0;
    end else begin
      win_st_q <= rst_st_q;
      if (rst_st_q != win_st_q) begin
        win_len_q <= CNT_W'(1);
      end else begin
        win_len_q <= win_len_q + CNT_W'(1);
      end
    end
  end

  // Security is sampled during the peripheral window, while the peripherals are still held in reset.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      secure_q      <= 1'b1;
      dbg_rd_dis_q  <= 1'b1;
      dbg_port_en_q <= 1'b0;
    end else if (rst_st_q == RPMS_RST_PERI) begin
      secure_q      <= rpms_is_secure(i_sec_bytes); // R12 R13
      dbg_rd_dis_q  <= rpms_is_secure(i_sec_bytes); // R15
      dbg_port_en_q <= !rpms_is_secure(i_sec_bytes); // R12
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || any_rst) begin
      dis_temp_q     <= 1'b0;
      dis_perm_q     <= 1'b0;
      stopwait_dis_q <= 1'b0;
    end else if (i_dis_wr) begin
      dis_temp_q     <= i_dis_temp; // R08
      dis_perm_q     <= dis_perm_q | i_dis_perm; // R08
      stopwait_dis_q <= i_dis_temp | dis_perm_q | i_dis_perm; // R08
    end
  end

  // A wake pass through WAKE restores clocks one cycle before the core may run again.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || any_rst) begin
      pwr_q <= RPMS_PWR_RUN;
    end else begin
      unique case (pwr_q)
        RPMS_PWR_RUN: begin
          if (rst_st_q == RPMS_RST_DONE && !(dis_temp_q || dis_perm_q)) begin // R08
            if (i_stop_insn) begin
              pwr_q <= RPMS_PWR_STOP;
            end else if (i_wait_insn) begin
              pwr_q <= RPMS_PWR_WAIT;
            end
          end
        end
        RPMS_PWR_WAIT: begin
          if (i_periph_irq || i_unclk_irq) begin // R04
            pwr_q <= RPMS_PWR_WAKE;
          end
        end
        RPMS_PWR_STOP: begin
          if (i_can_act || i_unclk_irq) begin // R05
            pwr_q <= RPMS_PWR_WAKE;
          end
        end
        RPMS_PWR_WAKE: begin
          pwr_q <= RPMS_PWR_RUN; // R17
        end
      endcase
    end
  end

  // Core enable only opens once back in RUN; WAKE restarts peripherals first.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      clk_en_q <= '0;
    end else begin
      clk_en_q.core_en <= half_en && rst_n_q.sim_rst_n && (pwr_q == RPMS_PWR_RUN); // R01 R02 R03 R17
      clk_en_q.peri_en <= half_en && rst_n_q.sim_rst_n
                          && (pwr_q != RPMS_PWR_STOP); // R02 R03 R06
      // The watchdog keeps ticking in every mode so it can end Stop by reset.
      clk_en_q.wdog_en <= half_en; // R05 R06
    end
  end

  // Test access ignores the security state; the flop only keeps outputs registered.
  always_ff @(posedge i_clk) begin
    tap_en_q <= 1'b1; // R14
  end

  assign o_clk_en       = clk_en_q;
  assign o_rst_n        = rst_n_q;
  assign o_pwr_mode     = pwr_q;
  assign o_secure       = secure_q;
  assign o_dbg_rd_dis   = dbg_rd_dis_q; // R15
  assign o_dbg_port_en  = dbg_port_en_q; // R12
  assign o_tap_en       = tap_en_q; // R14
  assign o_stopwait_dis = stopwait_dis_q;

  chk_core_after_peri: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R16
    o_rst_n.core_rst_n |-> o_rst_n.peri_rst_n) else $error("core released before peripherals");
  chk_peri_after_sim: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R16
    o_rst_n.peri_rst_n |-> o_rst_n.sim_rst_n) else $error("peripherals released before clocking");
  chk_wait_gates_core: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R03
    pwr_q == RPMS_PWR_WAIT |=> !o_clk_en.core_en) else $error("core clock ran in wait");
  chk_stop_gates_peri: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R05
    pwr_q == RPMS_PWR_STOP |=> !o_clk_en.peri_en) else $error("peripheral clock ran in stop");
  chk_wait_irq_wake: assert property (@(posedge i_clk) disable iff (!i_rst_n || any_rst) // R04
    pwr_q == RPMS_PWR_WAIT && i_periph_irq |=> pwr_q == RPMS_PWR_WAKE ##1 pwr_q == RPMS_PWR_RUN)
    else $error("wait not left on interrupt");
  chk_stop_holds: assert property (@(posedge i_clk) disable iff (!i_rst_n || any_rst) // R05
    pwr_q == RPMS_PWR_STOP && !i_can_act && !i_unclk_irq |=> pwr_q == RPMS_PWR_STOP)
    else $error("stop left without a wake event");
  chk_disable_blocks: assert property (@(posedge i_clk) disable iff (!i_rst_n || any_rst) // R08
    pwr_q == RPMS_PWR_RUN && o_stopwait_dis |=> pwr_q == RPMS_PWR_RUN)
    else $error("stop or wait entered while disabled");
  chk_perm_sticks: assert property (@(posedge i_clk) disable iff (!i_rst_n || any_rst) // R08
    dis_perm_q |=> dis_perm_q) else $error("permanent disable dropped without reset");
  // Reset release order, window timing and Run held during the sequence.
  chk_window_len: assert property (@(posedge i_clk) disable iff (!i_rst_n || any_rst) // R10
    win_st_q inside {RPMS_RST_CLK, RPMS_RST_PERI, RPMS_RST_CORE} && rst_st_q != win_st_q
    |-> win_len_q == WIN_LEN) else $error("reset window not 32 cycles");
  chk_window_order: assert property (@(posedge i_clk) disable iff (!i_rst_n || any_rst) // R16
    win_st_q == RPMS_RST_PERI |-> rst_st_q inside {RPMS_RST_PERI, RPMS_RST_CORE})
    else $error("peripheral window not followed by core window");
  chk_sim_held: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R11
    rst_st_q == RPMS_RST_HOLD |=> !o_rst_n.sim_rst_n)
    else $error("clocking released during hold");
  chk_peri_held: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R16
    rst_st_q inside {RPMS_RST_HOLD, RPMS_RST_CLK, RPMS_RST_PERI} |=> !o_rst_n.peri_rst_n)
    else $error("peripherals released before their window ended");
  chk_core_held: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R16
    rst_st_q != RPMS_RST_DONE |=> !o_rst_n.core_rst_n)
    else $error("core released before its window ended");
  chk_refused_early: assert property (@(posedge i_clk) disable iff (!i_rst_n || any_rst) // R16
    pwr_q == RPMS_PWR_RUN && rst_st_q != RPMS_RST_DONE |=> pwr_q == RPMS_PWR_RUN)
    else $error("power mode left run during reset sequence");

  // Power mode clocking.
  chk_wake_one_cycle: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R17
    pwr_q == RPMS_PWR_WAKE |=> pwr_q == RPMS_PWR_RUN)
    else $error("wake state did not return to run");
  chk_core_only_run: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R17
    o_clk_en.core_en |-> $past(pwr_q) == RPMS_PWR_RUN)
    else $error("core clock enabled outside run");
  chk_stop_core_off: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R05
    pwr_q == RPMS_PWR_STOP |=> !o_clk_en.core_en)
    else $error("core clock ran in stop");
  chk_peri_in_wait: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R03
    pwr_q == RPMS_PWR_WAIT && half_en && o_rst_n.sim_rst_n |=> o_clk_en.peri_en)
    else $error("peripheral clock missing in wait");
  chk_core_with_wdog: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R06
    o_clk_en.core_en |-> o_clk_en.wdog_en)
    else $error("core clock off the shared half rate");
  chk_wdog_free: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R05
    o_clk_en.wdog_en |=> !o_clk_en.wdog_en ##1 o_clk_en.wdog_en)
    else $error("watchdog clock stopped");

  // Disable flags, security outputs and reset assertion.
  chk_stopwait_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R08
    o_stopwait_dis == (dis_temp_q || dis_perm_q))
    else $error("disable output differs from disable state");
  chk_temp_follows: assert property (@(posedge i_clk) disable iff (!i_rst_n || any_rst) // R08
    i_dis_wr && i_dis_temp |=> o_stopwait_dis)
    else $error("temporary disable not taken");
  chk_secure_steady: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R12
    rst_st_q != RPMS_RST_PERI |=> $stable(o_secure))
    else $error("security changed outside peripheral window");
  chk_dbg_match: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R15
    o_dbg_rd_dis == o_secure)
    else $error("debug read disable differs from security");
  chk_reset_asserts: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R09
    any_rst |=> o_rst_n == '0) else $error("reset source did not assert resets");
  chk_dbg_follows: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R15
    o_dbg_rd_dis != o_dbg_port_en) else $error("debug disable inconsistent");
endmodule // rpms_sequencer
`default_nettype wire

// file: rtl/rpms_pkg.sv
// Contract
// R01 - System and peripheral clock enables run at half the master clock rate, at most 60 MHz.
// R02 - In Run mode both core and peripheral clocks are enabled.
// R03 - In Wait mode core and memory clocks are gated while peripheral clocks keep running.
// R04 - Any unmasked peripheral interrupt in Wait mode restarts the core clocks.
// R05 - Stop mode is left only on CAN activity, a non-clocked interrupt, or a reset.
// R06 - Every peripheral except the watchdog timer is clocked by the peripheral bus clock.
// R07 - Software shuts the PLL down and selects the oscillator before executing stop.
// R08 - A control write disables stop and wait temporarily or permanently until next reset.
// R09 - Four reset sources: external pin and power-on asynchronous, software and watchdog synchronous; here all four are sampled on the rising edge.
// R10 - Power-on reset is held 2^21 cycles, then three 32-cycle windows release clocking, peripherals, core.
// R11 - Resets assert asynchronously but are released on a rising system clock edge; here assertion also waits for the next rising edge.
// R12 - Two flash security bytes decide security, and when secured the core debug port is disabled.
// R13 - At boot the block selects unsecured mode or secure mode with debug disabled.
// R14 - The chip-level test access port is active at boot whatever the security state.
// R15 - At reset the debug-read-disable output follows the flash security bytes.
// R16 - Later-released blocks stay in reset until their own window ends, for every source.
// R17 - Leaving Wait or Stop on an interrupt restores Run clocking before the core resumes.
package rpms_pkg;

  localparam int unsigned MASTER_MHZ      = 120;
  localparam int unsigned CLK_MHZ         = 50;
  localparam int unsigned POR_EXT_LOG2    = 21;
  localparam int unsigned WINDOW_CYCLES   = 32;
  localparam int unsigned CNT_W           = 22;
  localparam logic [15:0] SECURE_KEY      = 16'hE70A;

  typedef enum logic [3:0] {
    RPMS_PWR_RUN  = 4'h1,
    RPMS_PWR_WAIT = 4'h2,
    RPMS_PWR_STOP = 4'h4,
    RPMS_PWR_WAKE = 4'h8
  } rpms_pwr_e;

  typedef enum logic [4:0] {
    RPMS_RST_HOLD = 5'h01,
    RPMS_RST_CLK  = 5'h02,
    RPMS_RST_PERI = 5'h04,
    RPMS_RST_CORE = 5'h08,
    RPMS_RST_DONE = 5'h10
  } rpms_rst_e;

  typedef struct packed {
    logic core_rst_n;
    logic peri_rst_n;
    logic sim_rst_n;
  } rpms_rst_s;

  typedef struct packed {
    logic core_en;
    logic peri_en;
    logic wdog_en;
  } rpms_clk_s;

  function automatic logic rpms_is_secure(input logic [15:0] b);
    return b == SECURE_KEY;
  endfunction

endpackage

// file: rtl/rpms_clkdiv.sv
`timescale 1ns/1ps
`default_nettype none
module rpms_clkdiv (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  output logic      o_half_en
);
  // Half-rate enable toggles every cycle; reset makes the first enable land one edge later.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_half_en <= 1'b0;
    end else begin
      o_half_en <= ~o_half_en; // R01
    end
  end

  chk_half_alternates: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R01
    o_half_en |=> !o_half_en) else $error("half enable did not alternate");
endmodule // rpms_clkdiv
`default_nettype wire

// file: test/rpms_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module rpms_core_model (
  input  wire logic       i_clk,
  input  wire logic       i_core_rst_n,
  input  wire logic       i_core_en,
  input  wire logic [1:0] i_cmd,
  output logic            o_wait_insn,
  output logic            o_stop_insn,
  output int unsigned     o_steps
);
  logic [1:0] pend;
  initial begin
    pend = 2'b00;
    o_wait_insn = 1'b0;
    o_stop_insn = 1'b0;
    o_steps = 0;
  end
  // The core retires work only on its own enable, so a gated clock shows as a frozen count.
  always @(posedge i_clk) begin
    pend <= i_cmd;
    if (i_core_rst_n && i_core_en) o_steps <= o_steps + 1;
  end
  // The model has no PLL, so stop always finds the oscillator already selected.
  always @(negedge i_clk) begin
    o_wait_insn <= pend[0] & i_core_rst_n;
    o_stop_insn <= pend[1] & i_core_rst_n;
  end
endmodule // rpms_core_model
`default_nettype wire

// file: test/reset_power_mode_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) check(n, 32'(e), 32'(g));
module reset_power_mode_sequencer_tb;
  import rpms_pkg::*;
  localparam int unsigned POR_N = 64;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [3:0]  src = 4'h0;
  logic [1:0]  dis = 2'b00;
  logic        dis_wr = 1'b0;
  logic [2:0]  irq = 3'b000;
  logic [15:0] sec = 16'h0000;
  logic [1:0]  cmd = 2'b00;
  logic        wait_insn, stop_insn, secure, rd_dis, port_en, tap_en, sw_dis;
  int unsigned steps;
  rpms_clk_s   clk_en;
  rpms_rst_s   rst;
  rpms_pwr_e   mode;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          seed = 44;
  always #10 i_clk = ~i_clk;
  rpms_sequencer #(.POR_CYCLES(POR_N)) dut_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_por(src[0]), .i_ext_rst(src[1]),
    .i_sw_rst(src[2]), .i_wdog_rst(src[3]), .i_stop_insn(stop_insn),
    .i_wait_insn(wait_insn), .i_dis_temp(dis[0]), .i_dis_perm(dis[1]),
    .i_dis_wr(dis_wr), .i_periph_irq(irq[0]), .i_unclk_irq(irq[1]),
    .i_can_act(irq[2]), .i_sec_bytes(sec), .o_clk_en(clk_en), .o_rst_n(rst),
    .o_pwr_mode(mode), .o_secure(secure), .o_dbg_rd_dis(rd_dis),
    .o_dbg_port_en(port_en), .o_tap_en(tap_en), .o_stopwait_dis(sw_dis));
  rpms_core_model core_u (.i_clk(i_clk), .i_core_rst_n(rst.core_rst_n),
    .i_core_en(clk_en.core_en), .i_cmd(cmd), .o_wait_insn(wait_insn),
    .o_stop_insn(stop_insn), .o_steps(steps));
  function automatic logic exp_sec(input logic [15:0] b);
    return b === SECURE_KEY;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
      n_mismatch++;
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic run_seq(output int s, output int p, output int c);
    s = -1;
    p = -1;
    c = -1;
    for (int k = 0; k < 400 && c < 0; k++) begin
      @(negedge i_clk);
      if (s < 0 && rst.sim_rst_n === 1'b1) s = k;
      if (p < 0 && rst.peri_rst_n === 1'b1) p = k;
      if (c < 0 && rst.core_rst_n === 1'b1) c = k;
    end
    if (c < 0) begin
      n_mismatch++;
      finish_test();
    end
  endtask
  task automatic count_en(input int n, output int cc, output int pc, output int wc);
    cc = 0;
    pc = 0;
    wc = 0;
    repeat (n) begin
      @(negedge i_clk);
      cc += clk_en.core_en;
      pc += clk_en.peri_en;
      wc += clk_en.wdog_en;
    end
  endtask
  task automatic ctl(input logic [1:0] d);
    dis = d;
    dis_wr = 1'b1;
    tick(1);
    dis_wr = 1'b0;
    tick(2);
  endtask
  task automatic insn(input logic [1:0] v);
    cmd = v;
    tick(1);
    cmd = 2'b00;
    tick(4);
  endtask
  task automatic wake_up();
    logic seen;
    seen = 1'b0;
    for (int k = 0; k < 6; k++) begin
      @(negedge i_clk);
      if (mode === RPMS_PWR_WAKE) seen = 1'b1;
      if (mode !== RPMS_PWR_RUN) `CHK("core_gated", 0, clk_en.core_en)
    end
    irq = 3'b000;
    `CHK("wake_seen", 1, seen)
    `CHK("mode_run", RPMS_PWR_RUN, mode)
  endtask
  initial begin
    int s, p, c, cc, pc, wc;
    int unsigned st;
    logic [15:0] key;
    tick(8);
    `CHK("rst_held", 3'b000, rst)
    `CHK("mode_rst", RPMS_PWR_RUN, mode)
    `CHK("port_rst", 0, port_en)
    `CHK("rd_dis_rst", 1, rd_dis)
    `CHK("tap_rst", 1, tap_en)
    i_rst_n = 1'b1;
    run_seq(s, p, c);
    `CHK("por_hold", 1, s >= POR_N)
    `CHK("peri_gap", 64, p - s)
    `CHK("core_gap", 32, c - p)
    count_en(40, cc, pc, wc);
    `CHK("core_rate", 20, cc)
    `CHK("peri_rate", 20, pc)
    `CHK("wdog_rate", 20, wc)
    ctl(2'b01);
    `CHK("dis_temp", 1, sw_dis)
    insn(2'b01);
    `CHK("wait_refused", RPMS_PWR_RUN, mode)
    ctl(2'b00);
    `CHK("dis_clear", 0, sw_dis)
    ctl(2'b10);
    ctl(2'b00);
    `CHK("dis_perm", 1, sw_dis)
    // Sources are levels, so each is held two edges to be sure it is seen.
    for (int k = 0; k < 4; k++) begin
      key = (k % 2) ? SECURE_KEY : 16'($random(seed));
      sec = key;
      ctl(2'b10);
      src[k] = 1'b1;
      tick(2);
      `CHK("src_assert", 3'b000, rst)
      src[k] = 1'b0;
      run_seq(s, p, c);
      `CHK("hold_len", k == 0, s >= POR_N)
      `CHK("peri_gap", 64, p - s)
      `CHK("core_gap", 32, c - p)
      `CHK("perm_gone", 0, sw_dis)
      `CHK("secure", exp_sec(key), secure)
      `CHK("rd_dis", exp_sec(key), rd_dis)
      `CHK("dbg_port", !exp_sec(key), port_en)
      `CHK("tap", 1, tap_en)
    end
    insn(2'b01);
    `CHK("mode_wait", RPMS_PWR_WAIT, mode)
    st = steps;
    count_en(20, cc, pc, wc);
    `CHK("wait_core", 0, cc)
    `CHK("wait_peri", 10, pc)
    `CHK("wait_wdog", 10, wc)
    `CHK("core_frozen", st, steps)
    tick(1 + ($random(seed) & 7));
    irq = 3'b001;
    wake_up();
    count_en(20, cc, pc, wc);
    `CHK("core_back", 10, cc)
    for (int j = 1; j < 3; j++) begin
      insn(2'b10);
      `CHK("mode_stop", RPMS_PWR_STOP, mode)
      irq = 3'b001;
      count_en(20, cc, pc, wc);
      `CHK("stop_holds", RPMS_PWR_STOP, mode)
      `CHK("stop_core", 0, cc)
      `CHK("stop_peri", 0, pc)
      `CHK("stop_wdog", 10, wc)
      irq = 3'b000;
      tick(1);
      irq[j] = 1'b1;
      wake_up();
    end
    finish_test();
  end
endmodule // reset_power_mode_sequencer_tb
`default_nettype wire
